// [verilog/rcs_pkg.sv]
// shared constants, types and reset values of the reset-cause sequencer
`default_nettype none
package rcs_pkg;
	// register map, byte addresses on the bus
	localparam logic [7:0] ADR_PWR_STAT = 8'h00;
	localparam logic [7:0] ADR_CORE_STAT = 8'h04;
	localparam logic [7:0] ADR_CONFIG = 8'h08;
	localparam logic [7:0] ADR_OPTION = 8'h0c;
	localparam logic [7:0] ADR_DATA_HOLD = 8'h10;
	localparam logic [7:0] ADR_CAUSE = 8'h14;
	// power_reset_status fields
	localparam int BROWNOUT_FLAG_BIT = 0;
	localparam int POR_BIT = 1;
	// core status fields
	localparam int PAGE_LSB = 5;
	localparam int TIMEOUT_FLAG_BIT = 4;
	localparam int POWERDOWN_FLAG_BIT = 3;
	// config fields
	localparam int PUT_ENABLE_N_BIT = 0;
	localparam int BODEN_BIT = 1;
	localparam int MODE_LSB = 2;
	// reset values
	localparam logic [1:0] PWR_STAT_POR = 2'h0;
	localparam logic [7:0] CORE_STAT_POR = 8'h18;
	localparam logic [7:0] CONFIG_POR = 8'h06;
	localparam logic [7:0] OPTION_RST = 8'hff;
	localparam logic [7:0] DATA_POR = 8'h00;
	// program counter
	localparam int PC_W = 13;
	localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	// timing
	localparam longint CLK_HZ = 64'd50000000;
	localparam longint POWERUP_MS = 64'd72;
	localparam longint POWERUP_CYCLES_L = POWERUP_MS * CLK_HZ / 64'd1000;
	localparam int CNT_W = 22;
	localparam logic [CNT_W-1:0] STARTUP_CYCLES = 22'h000400;

	typedef enum logic [1:0] {
		OSC_CRYSTAL_LOWPOWER = 2'h0,
		OSC_CRYSTAL_STD = 2'h1,
		OSC_CRYSTAL_FAST = 2'h2,
		OSC_RC = 2'h3
	} rcs_osc_mode_t;

	typedef enum logic [2:0] {
		ST_RUN, ST_HOLD, ST_POWERUP_WAIT, ST_STARTUP_WAIT, ST_DONE
	} rcs_state_t;
	typedef enum logic [2:0] {
		CAUSE_POR, CAUSE_BROWNOUT, CAUSE_PIN, CAUSE_WDT, CAUSE_WAKE
	} rcs_cause_t;

	// one register access handed from the bus slave to the register file
	typedef struct packed {
		logic wr;
		logic [7:0] adr;
		logic [7:0] wdat;
	} rcs_reg_acc_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rcs_wb_st_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic busy;
		logic done;
	} rcs_cnt_st_t;

	typedef struct packed {
		logic pin_s1;
		logic pin_s2;
		logic brownout_s1;
		logic brownout_s2;
		logic osc_s1;
		logic osc_s2;
		logic osc_s3;
		rcs_state_t state;
		rcs_cause_t cause;
		logic vec_irq;
		logic [1:0] pwr_stat;
		logic [7:0] core_stat;
		logic [7:0] config_reg;
		logic [7:0] option;
		logic [7:0] data_hold;
		logic put_go;
		logic startup_go;
		logic core_reset;
		logic core_hold;
		logic pc_load;
		logic [PC_W-1:0] pc_value;
	} rcs_top_st_t;

	localparam rcs_top_st_t TOP_RST = '{
		pin_s1: 1'b0, pin_s2: 1'b0, brownout_s1: 1'b0, brownout_s2: 1'b0,
		osc_s1: 1'b0, osc_s2: 1'b0, osc_s3: 1'b0,
		state: ST_HOLD, cause: CAUSE_POR, vec_irq: 1'b0,
		pwr_stat: PWR_STAT_POR, core_stat: CORE_STAT_POR, config_reg: CONFIG_POR,
		option: OPTION_RST, data_hold: DATA_POR,
		put_go: 1'b0, startup_go: 1'b0, core_reset: 1'b1, core_hold: 1'b0,
		pc_load: 1'b0, pc_value: RESET_VECTOR
	};
endpackage
`default_nettype wire

// [verilog/rcs_timeout_cnt.sv]
// down-counter that times one reset time-out in ticks
`default_nettype none
module rcs_timeout_cnt
	import rcs_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [W-1:0] len_i,
	input wire logic tick_i,
	output logic busy_o,
	output logic done_o
);
	rcs_cnt_st_t s, n;

	always_comb begin
		n = s;
		n.done = 1'b0;
		// a restart reloads and swallows any expiry of the old run
		if (start_i) begin
			n.cnt = len_i;
			n.busy = 1'b1;
		end else if (s.busy && tick_i) begin
			n.cnt = s.cnt - 1'b1;
			if (s.cnt <= W'(1)) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign busy_o = s.busy;
	assign done_o = s.done;
endmodule // rcs_timeout_cnt
`default_nettype wire

// [verilog/rcs_wb_slave.sv]
// classic wishbone slave front end for the byte-wide register file
`default_nettype none
module rcs_wb_slave
	import rcs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [7:0] rdata_i,
	output var rcs_reg_acc_t acc_o,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o
);
	rcs_wb_st_t s, n;
	logic req;

	always_comb begin
		req = wb_cyc_i && wb_stb_i;
		n = s;
		// ack one cycle after the request, dropped the cycle after
		n.ack = req && !s.ack;
		if (req && !s.ack) begin
			n.dat = {24'h000000, rdata_i};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// the write lands on the edge where the master sees ack
	// one driver for the whole struct
	assign acc_o = '{
		wr: req && wb_we_i && s.ack && wb_sel_i[0],
		adr: wb_adr_i,
		wdat: wb_dat_i[7:0]
	};
	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.dat;
endmodule // rcs_wb_slave
`default_nettype wire

// [verilog/rcs_reset_seq.sv]
// reset cause recording, time-out sequencing and register file
// What this block does
// RL1 - brown-out flag, active low, at bit 0
// RL2 - software sets brown-out flag after power-on
// RL3 - brown-out flag meaningless while detection disabled
// RL4 - brown-out clears flag, sets timeout, powerdown
// RL5 - power-on flag at bit 1, power-on only
// RL6 - software sets power-on flag after power-up
// RL7 - time-out length per oscillator mode, cause
// RL8 - power-on sets timeout, powerdown, clears power-on flag
// RL9 - watchdog reset or wake updates timeout, powerdown
// RL10 - pin reset when awake keeps both flags
// RL11 - sleeping pin reset, irq wake: timeout set
// RL12 - resets load pc zero, clear page bits
// RL13 - wake-ups resume at next address
// RL14 - irq wake with enable jumps to vector
// RL15 - registers follow their own reset class
// RL16 - unimplemented bits read as zero
// RL17 - oscillator start-up only crystal, power-on, brown-out, wake
// RL18 - brown-out detection forces power-up timer on
// RL19 - start-up count follows power-up timer expiry
// RL20 - core held in reset while timers run, held by core_hold instead after a wake
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`default_nettype none
module rcs_reset_seq
	import rcs_pkg::*;
#(
	parameter int unsigned PUT_CYCLES = int'(POWERUP_CYCLES_L)
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire logic master_clear_pin_n_i,
	input wire logic brownout_i,
	input wire logic osc_clk_i,
	input wire logic wdt_expire_i,
	input wire logic irq_wake_i,
	input wire logic sleep_i,
	input wire logic global_irq_enable_i,
	input wire logic [PC_W-1:0] pc_i,
	output logic core_reset_o,
	output logic core_hold_o,
	output logic pc_load_o,
	output logic [PC_W-1:0] pc_value_o
);
	rcs_top_st_t s, n;
	rcs_reg_acc_t acc;
	logic [7:0] rdata;
	logic put_done;
	logic startup_done;
	logic osc_tick;
	logic boden;
	logic crystal;
	logic put_on;
	logic brownout_act;
	logic pin_low;

	rcs_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.rdata_i(rdata),
		.acc_o(acc),
		.wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o)
	);

	// power-up timer runs on the core clock standing in for the internal rc
	rcs_timeout_cnt #(.W(CNT_W)) u_put (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(s.put_go),
		.len_i(CNT_W'(PUT_CYCLES)),
		.tick_i(1'b1),
		.busy_o(),
		.done_o(put_done)
	);

	// start-up timer counts rising edges of the oscillator pin
	rcs_timeout_cnt #(.W(CNT_W)) u_startup (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(s.startup_go),
		.len_i(STARTUP_CYCLES),
		.tick_i(osc_tick),
		.busy_o(),
		.done_o(startup_done)
	);

	// read mux; unmapped offsets return zero
	always_comb begin
		case (acc.adr)
			ADR_PWR_STAT: rdata = {6'h00, s.pwr_stat}; // RL16
			ADR_CORE_STAT: rdata = s.core_stat;
			ADR_CONFIG: rdata = {4'h0, s.config_reg[3:0]}; // RL16
			ADR_OPTION: rdata = s.option;
			ADR_DATA_HOLD: rdata = s.data_hold;
			ADR_CAUSE: rdata = {2'h0, s.state, s.cause};
			default: rdata = 8'h00;
		endcase
	end

	always_comb begin
		n = s;
		n.put_go = 1'b0;
		n.startup_go = 1'b0;
		n.pc_load = 1'b0;

		// pins cross in through two flops and only the second is read; the oscillator adds a third for its edge
		n.pin_s1 = master_clear_pin_n_i;
		n.pin_s2 = s.pin_s1;
		n.brownout_s1 = brownout_i;
		n.brownout_s2 = s.brownout_s1;
		n.osc_s1 = osc_clk_i;
		n.osc_s2 = s.osc_s1;
		n.osc_s3 = s.osc_s2;

		boden = s.config_reg[BODEN_BIT];
		crystal = s.config_reg[MODE_LSB +: 2] != OSC_RC;
		put_on = !s.config_reg[PUT_ENABLE_N_BIT] || boden; // RL18
		brownout_act = boden && s.brownout_s2; // RL3
		pin_low = !s.pin_s2;
		osc_tick = s.osc_s2 && !s.osc_s3 && crystal; // RL17

		// software writes first, so a hardware event in the same cycle wins
		if (acc.wr) begin
			case (acc.adr)
				ADR_PWR_STAT: n.pwr_stat = acc.wdat[1:0]; // RL2 RL6
				ADR_CORE_STAT: begin
					n.core_stat[7:PAGE_LSB] = acc.wdat[7:PAGE_LSB];
					n.core_stat[2:0] = acc.wdat[2:0];
				end
				ADR_CONFIG: n.config_reg = {4'h0, acc.wdat[3:0]};
				ADR_OPTION: n.option = acc.wdat;
				ADR_DATA_HOLD: n.data_hold = acc.wdat; // RL15
				default: n.data_hold = n.data_hold;
			endcase
		end

		// brown-out holds the core in any state and restarts the sequence
		if (brownout_act) begin
			n.state = ST_HOLD;
			n.cause = CAUSE_BROWNOUT;
			n.core_reset = 1'b1; // RL20
			n.core_hold = 1'b0;
			n.pwr_stat[BROWNOUT_FLAG_BIT] = 1'b0; // RL4 RL1
			n.core_stat[TIMEOUT_FLAG_BIT] = 1'b1; // RL4
			n.core_stat[POWERDOWN_FLAG_BIT] = 1'b1; // RL4
			n.core_stat[7:PAGE_LSB] = 3'h0; // RL12
			n.option = OPTION_RST; // RL15
		end else begin
			case (s.state)
				ST_RUN: begin
					if (pin_low) begin
						n.state = ST_HOLD;
						n.cause = CAUSE_PIN;
						n.core_reset = 1'b1;
						n.core_stat[7:PAGE_LSB] = 3'h0; // RL12
						n.option = OPTION_RST; // RL15
						// awake, the flags stay as they are
						if (sleep_i) begin // RL10
							n.core_stat[TIMEOUT_FLAG_BIT] = 1'b1; // RL11
							n.core_stat[POWERDOWN_FLAG_BIT] = 1'b0; // RL11
						end
					end else if (wdt_expire_i && sleep_i) begin
						n.cause = CAUSE_WAKE;
						n.vec_irq = 1'b0;
						n.core_stat[TIMEOUT_FLAG_BIT] = 1'b0; // RL9
						n.core_stat[POWERDOWN_FLAG_BIT] = 1'b0; // RL9
						n.core_hold = 1'b1;
						n.state = crystal ? ST_STARTUP_WAIT : ST_DONE; // RL7 RL17
						n.startup_go = crystal;
					end else if (wdt_expire_i) begin
						n.state = ST_HOLD;
						n.cause = CAUSE_WDT;
						n.core_reset = 1'b1;
						n.core_stat[TIMEOUT_FLAG_BIT] = 1'b0; // RL9
						n.core_stat[POWERDOWN_FLAG_BIT] = 1'b1; // RL9
						n.core_stat[7:PAGE_LSB] = 3'h0; // RL12
						n.option = OPTION_RST; // RL15
					end else if (irq_wake_i && sleep_i) begin
						n.cause = CAUSE_WAKE;
						n.vec_irq = global_irq_enable_i; // RL14
						n.core_stat[TIMEOUT_FLAG_BIT] = 1'b1; // RL11
						n.core_stat[POWERDOWN_FLAG_BIT] = 1'b0; // RL11
						n.core_hold = 1'b1;
						n.state = crystal ? ST_STARTUP_WAIT : ST_DONE; // RL7 RL17
						n.startup_go = crystal;
					end
				end
				ST_HOLD: begin
					// power-on and brown-out run the timers even with the pin low
					if (s.cause == CAUSE_POR || s.cause == CAUSE_BROWNOUT) begin
						if (put_on) begin // RL7
							n.state = ST_POWERUP_WAIT;
							n.put_go = 1'b1;
						end else if (crystal) begin // RL17
							n.state = ST_STARTUP_WAIT;
							n.startup_go = 1'b1;
						end else begin
							n.state = ST_DONE;
						end
					end else begin
						n.state = ST_DONE;
					end
				end
				ST_POWERUP_WAIT: begin
					if (put_done) begin // RL19
						n.state = crystal ? ST_STARTUP_WAIT : ST_DONE; // RL7
						n.startup_go = crystal;
					end
				end
				ST_STARTUP_WAIT: begin
					if (startup_done) begin // RL19
						n.state = ST_DONE;
					end
				end
				ST_DONE: begin
					// a pin held low keeps the core back after the timers expire
					if (!pin_low) begin
						n.state = ST_RUN;
						n.core_reset = 1'b0; // RL20
						n.core_hold = 1'b0;
						n.pc_load = 1'b1;
						if (s.cause != CAUSE_WAKE) begin
							n.pc_value = RESET_VECTOR; // RL12
						end else if (s.vec_irq) begin
							n.pc_value = IRQ_VECTOR; // RL14
						end else begin
							n.pc_value = pc_i + PC_W'(1); // RL13
						end
					end
				end
				default: begin
					n.state = ST_HOLD;
					n.core_reset = 1'b1;
				end
			endcase
		end
	end

	// reset constant clears the power-on flag and sets timeout and powerdown
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= TOP_RST; // RL5 RL8 RL12 RL15
		end else begin
			s <= n;
		end
	end

	assign core_reset_o = s.core_reset;
	assign core_hold_o = s.core_hold;
	assign pc_load_o = s.pc_load;
	assign pc_value_o = s.pc_value;
endmodule // rcs_reset_seq
`default_nettype wire

// [dv/rcs_reset_seq_sva.sv]
// port checker for the reset-cause sequencer
`default_nettype none
module rcs_reset_seq_sva
	import rcs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic master_clear_pin_n_i,
	input wire logic brownout_i,
	input wire logic wdt_expire_i,
	input wire logic irq_wake_i,
	input wire logic sleep_i,
	input wire logic global_irq_enable_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic core_reset_o,
	input wire logic core_hold_o,
	input wire logic pc_load_o,
	input wire logic [PC_W-1:0] pc_value_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// pins quiet so no higher-priority event competes
	sequence s_awake;
		!core_reset_o && !core_hold_o && !pc_load_o && master_clear_pin_n_i && !brownout_i;
	endsequence
	sequence s_hold_end;
		core_hold_o ##1 (!core_hold_o && pc_load_o);
	endsequence
	sequence s_irq_gie;
		s_awake and (sleep_i && irq_wake_i && !wdt_expire_i && global_irq_enable_i);
	endsequence
	sequence s_wdt_wake;
		s_awake and (sleep_i && wdt_expire_i);
	endsequence
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than a cycle");
	a_upper_zero: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper data set");
	a_release_held: assert property ($fell(rst_i) |-> core_reset_o && !pc_load_o)
		else $error("core not held after reset");
	a_reset_vector: assert property ($fell(core_reset_o) |-> pc_load_o && pc_value_o == RESET_VECTOR)
		else $error("release without vector zero");
	a_pc_pulse: assert property (pc_load_o |=> !pc_load_o) else $error("pc load not a pulse");
	a_wdt_reset: assert property (s_awake and (wdt_expire_i && !sleep_i) |=> core_reset_o)
		else $error("watchdog reset not taken");
	a_wake_hold: assert property (s_wdt_wake or s_irq_gie |=> core_hold_o && !core_reset_o)
		else $error("wake not held");
	a_irq_vector: assert property (s_irq_gie ##1 s_hold_end |-> pc_value_o == IRQ_VECTOR)
		else $error("irq wake missed vector");
	a_wdt_next: assert property (s_wdt_wake ##1 s_hold_end |-> pc_value_o == pc_i + 13'h1)
		else $error("watchdog wake not next address");
endmodule // rcs_reset_seq_sva
bind rcs_reset_seq rcs_reset_seq_sva rcs_reset_seq_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .wb_dat_o, .master_clear_pin_n_i, .brownout_i, .wdt_expire_i, .irq_wake_i,
	.sleep_i, .global_irq_enable_i, .pc_i, .core_reset_o, .core_hold_o, .pc_load_o, .pc_value_o);
`default_nettype wire

// [dv/tb_rcs_reset_seq.sv]
// self-checking bench for the reset-cause sequencer
`default_nettype none
module tb_rcs_reset_seq
	import rcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pin_n = 1, brownout = 0, osc = 0;
	logic wdt = 0, irq = 0, slp = 0, global_irq_enable = 0, ack, crst, hold, pld;
	logic [7:0] adr = 8'h00;
	// wsel is what the next bus call puts on sel
	logic [3:0] sel = 4'hf, wsel = 4'hf;
	logic [31:0] dat = 32'h0, q, rdat;
	logic [PC_W-1:0] pc = 13'h0123, last_pc, pcv;
	int fails = 0, checks = 0, n;
	// short power-up timer keeps the run brief
	rcs_reset_seq #(.PUT_CYCLES(20)) rcs_reset_seq_i (.clk_i, .rst_i, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_ack_o(ack), .wb_dat_o(rdat), .master_clear_pin_n_i(pin_n), .brownout_i(brownout),
		.osc_clk_i(osc), .wdt_expire_i(wdt), .irq_wake_i(irq), .sleep_i(slp),
		.global_irq_enable_i(global_irq_enable), .pc_i(pc), .core_reset_o(crst), .core_hold_o(hold),
		.pc_load_o(pld), .pc_value_o(pcv));
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	// oscillator at half the core rate, so start-up takes 2048 cycles
	always @(posedge clk_i) osc <= ~osc;
	always @(posedge clk_i) if (pld === 1'b1) last_pc <= pcv;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= wsel;
		adr <= a;
		dat <= {24'h0, d};
		@(posedge clk_i);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k == 20) chk(32'h0, 32'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h0);
		chk(q, {24'h0, e});
	endtask
	task automatic ev(input logic w, input logic i);
		@(posedge clk_i);
		wdt <= w;
		irq <= i;
		@(posedge clk_i);
		wdt <= 1'b0;
		irq <= 1'b0;
	endtask
	task automatic pin_pulse;
		@(posedge clk_i);
		pin_n <= 1'b0;
		repeat (5) @(posedge clk_i);
		pin_n <= 1'b1;
	endtask
	// waits for the core to run again; n counts the wait
	task automatic settle;
		n = 0;
		repeat (3) @(posedge clk_i);
		while ((crst !== 1'b0 || hold !== 1'b0) && n < 4000) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 4000) chk(32'h0, 32'h1);
		slp <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		test_done;
	end
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		settle;
		chk({31'h0, n >= 2060}, 32'h1);
		rd(ADR_PWR_STAT, 8'h00);
		rd(ADR_CORE_STAT, 8'h18);
		rd(ADR_OPTION, 8'hff);
		rd(8'h20, 8'h00);
		rd(ADR_CAUSE, 8'h00);
		$display("test power_on done");
		wb(1'b1, ADR_CONFIG, 8'hff);
		rd(ADR_CONFIG, 8'h0f);
		wb(1'b1, ADR_PWR_STAT, 8'hff);
		rd(ADR_PWR_STAT, 8'h03);
		wb(1'b1, ADR_CORE_STAT, 8'he5);
		rd(ADR_CORE_STAT, 8'hfd);
		wb(1'b1, ADR_OPTION, 8'h12);
		wb(1'b1, ADR_DATA_HOLD, 8'h5a);
		ev(1'b1, 1'b0);
		settle;
		rd(ADR_CORE_STAT, 8'h0d);
		rd(ADR_PWR_STAT, 8'h03);
		rd(ADR_OPTION, 8'hff);
		rd(ADR_DATA_HOLD, 8'h5a);
		rd(ADR_CAUSE, 8'h03);
		// a write with the low lane off must not land
		wsel = 4'he;
		wb(1'b1, ADR_DATA_HOLD, 8'ha5);
		wsel = 4'hf;
		rd(ADR_DATA_HOLD, 8'h5a);
		$display("test watchdog_reset done");
		wb(1'b1, ADR_CORE_STAT, 8'he5);
		pin_pulse;
		settle;
		rd(ADR_CORE_STAT, 8'h0d);
		$display("test pin_reset done");
		wb(1'b1, ADR_CORE_STAT, 8'ha5);
		wb(1'b1, ADR_OPTION, 8'h34);
		slp <= 1'b1;
		ev(1'b1, 1'b0);
		settle;
		rd(ADR_CORE_STAT, 8'ha5);
		chk({19'h0, last_pc}, 32'h124);
		slp <= 1'b1;
		global_irq_enable <= 1'b1;
		ev(1'b0, 1'b1);
		settle;
		rd(ADR_CORE_STAT, 8'hb5);
		chk({19'h0, last_pc}, 32'h4);
		pc <= 13'h0456;
		global_irq_enable <= 1'b0;
		slp <= 1'b1;
		ev(1'b0, 1'b1);
		settle;
		chk({19'h0, last_pc}, 32'h457);
		rd(ADR_OPTION, 8'h34);
		$display("test wake_up done");
		slp <= 1'b1;
		pin_pulse;
		settle;
		rd(ADR_CORE_STAT, 8'h15);
		$display("test sleep_pin_reset done");
		brownout <= 1'b1;
		repeat (10) @(posedge clk_i);
		brownout <= 1'b0;
		settle;
		chk({31'h0, n >= 15}, 32'h1);
		rd(ADR_PWR_STAT, 8'h02);
		rd(ADR_CORE_STAT, 8'h1d);
		rd(ADR_CAUSE, 8'h01);
		$display("test brown_out done");
		// fast crystal mode: a wake must wait out the start-up count
		wb(1'b1, ADR_CONFIG, 8'h0b);
		slp <= 1'b1;
		ev(1'b1, 1'b0);
		settle;
		chk({31'h0, n >= 2040}, 32'h1);
		chk({19'h0, last_pc}, 32'h457);
		rd(ADR_CAUSE, 8'h04);
		$display("test crystal_wake done");
		test_done;
	end
endmodule // tb_rcs_reset_seq
`default_nettype wire
